/* File: verilog/dltx_controller.sv */
// Data-link transmit message controller with APB registers and two message buffers
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "dltx_defines.svh"

module dltx_controller
    import dltx_pkg::*;
#(
    parameter int BUF_DEPTH = 64,
    parameter int BIT_DIV   = 8
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             irq_out,
    output logic             dl_bit_out
);

    localparam int IW = $clog2(BUF_DEPTH);
    localparam int DW = $clog2(BIT_DIV);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    dltx_ctrl_s  ctrl_r;
    logic [6:0]  count_r;
    logic        sel_r;
    logic        busy_r;
    logic        busy_buf_r;
    logic        status_r;
    logic        mask_r;
    logic [7:0]  mem_r [2][BUF_DEPTH];
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        irq_r;

    logic        acc;
    logic        wr;
    logic        in_buf;
    logic        hit_ctrl;
    logic        hit_cnt;
    logic        hit_stat;
    logic        hit_mask;
    logic        next_free;
    logic        eot_pulse;

    assign acc      = psel_in && penable_in && !pready_r;
    assign wr       = acc && pwrite_in;
    assign in_buf   = (paddr_in[11:9] == `DLTX_BUF0_BASE >> 9)
                      && (paddr_in[`DLTX_BUF_IDX_HI-1:`DLTX_BUF_IDX_LO] < BUF_DEPTH);
    assign hit_ctrl = paddr_in == `DLTX_CTRL_ADDR;
    assign hit_cnt  = paddr_in == `DLTX_COUNT_ADDR;
    assign hit_stat = paddr_in == `DLTX_STATUS_ADDR;
    assign hit_mask = paddr_in == `DLTX_MASK_ADDR;
    assign next_free = busy_r ? ~busy_buf_r : sel_r;

    // ----------------------------------------------------------------
    // APB slave, one wait state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= acc;
            pslverr_r <= acc && !(hit_ctrl || hit_cnt || hit_stat || hit_mask || in_buf);
            prdata_r  <= '0;
            if (acc && !pwrite_in) begin
                if (hit_ctrl) begin
                    prdata_r[`DLTX_CTRL_ABDIS_BIT] <= ctrl_r.abort_disable;
                    prdata_r[`DLTX_CTRL_IDLE_BIT]  <= ctrl_r.force_idle;
                    prdata_r[`DLTX_CTRL_FCS_BIT]   <= ctrl_r.check_octet_append;
                    prdata_r[`DLTX_CTRL_TYPE_BIT]  <= ctrl_r.signalling_type_select;
                end else if (hit_cnt) begin
                    prdata_r[7:0] <= {next_free, count_r};
                end else if (hit_stat) begin
                    prdata_r[`DLTX_STAT_EOT_BIT] <= status_r;
                end else if (hit_mask) begin
                    prdata_r[`DLTX_STAT_EOT_BIT] <= mask_r;
                end else if (in_buf) begin
                    prdata_r[7:0] <= mem_r[paddr_in[`DLTX_BUF_SEL_BIT]]
                                          [paddr_in[`DLTX_BUF_IDX_LO +: IW]];
                end
            end
        end
    end

    assign prdata_out  = prdata_r;
    assign pready_out  = pready_r;
    assign pslverr_out = pslverr_r;

    always_ff @(posedge clk_in) begin
        if (wr && in_buf) begin
            mem_r[paddr_in[`DLTX_BUF_SEL_BIT]][paddr_in[`DLTX_BUF_IDX_LO +: IW]] <= pwdata_in[7:0];
        end
    end

    // Writing the count register starts a message
    logic start;
    assign start = wr && hit_cnt;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_r  <= '0;
            count_r <= `DLTX_COUNT_RESET;
            sel_r   <= 1'b0;
            mask_r  <= 1'b0;
        end else begin
            if (wr && hit_ctrl) begin
                ctrl_r.abort_disable          <= pwdata_in[`DLTX_CTRL_ABDIS_BIT];
                ctrl_r.force_idle             <= pwdata_in[`DLTX_CTRL_IDLE_BIT];
                ctrl_r.check_octet_append     <= pwdata_in[`DLTX_CTRL_FCS_BIT];
                ctrl_r.signalling_type_select <= pwdata_in[`DLTX_CTRL_TYPE_BIT];
            end
            if (start) begin
                count_r <= pwdata_in[6:0];
                sel_r   <= pwdata_in[`DLTX_COUNT_SEL_BIT];
            end
            if (wr && hit_mask) begin
                mask_r <= pwdata_in[`DLTX_STAT_EOT_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt: sticky, write one to clear, set wins
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_r <= 1'b0;
            irq_r    <= 1'b0;
        end else begin
            if (eot_pulse) begin
                status_r <= 1'b1;
            end else if (wr && hit_stat && pwdata_in[`DLTX_STAT_EOT_BIT]) begin
                status_r <= 1'b0;
            end
            irq_r <= (status_r || eot_pulse) && mask_r;
        end
    end

    assign irq_out = irq_r;

    // ----------------------------------------------------------------
    // Bit timing and octet sequencer
    // ----------------------------------------------------------------
    logic [DW-1:0] div_r;
    logic          tick;
    logic          take;
    assign tick = div_r == DW'(BIT_DIV - 1);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_r <= '0;
        end else begin
            div_r <= tick ? '0 : div_r + DW'(1);
        end
    end

    dltx_src_e   src;
    logic        mode_mos_r;
    logic [6:0]  idx_r;
    logic [6:0]  reps_r;
    logic        abort_pend_r;
    logic [15:0] fcs;
    logic        mos_active;
    dltx_octet_s oct;

    assign mos_active = busy_r && mode_mos_r && !ctrl_r.force_idle;

    always_comb begin
        oct = '{octet: `DLTX_FLAG_OCTET, stuff_en: 1'b0, first: 1'b0};
        src = DLTX_SRC_FLAG;
        if (abort_pend_r) begin
            src       = DLTX_SRC_ABORT;
            oct.octet = `DLTX_ABORT_OCTET;
        end else if (busy_r && !mode_mos_r) begin
            src       = DLTX_SRC_DATA;
            oct.octet = mem_r[busy_buf_r][idx_r[IW-1:0]];
        end else if (mos_active) begin
            oct.stuff_en = 1'b1;
            if (idx_r < count_r) begin
                src       = DLTX_SRC_DATA;
                oct.octet = mem_r[busy_buf_r][idx_r[IW-1:0]];
                oct.first = idx_r == '0;
            end else if (idx_r == count_r) begin
                src       = DLTX_SRC_FCS_LO;
                oct.octet = fcs[7:0];
            end else begin
                src       = DLTX_SRC_FCS_HI;
                oct.octet = fcs[15:8];
            end
        end
    end

    logic fcs_on;
    assign fcs_on = ctrl_r.check_octet_append && mode_mos_r;

    dltx_fcs16 u_fcs (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .init_in   (start),
        .update_in (take && src == DLTX_SRC_DATA && mos_active),
        .octet_in  (oct.octet),
        .fcs_out   (fcs)
    );

    dltx_serializer u_ser (
        .clk_in         (clk_in),
        .rst_n_in       (rst_n_in),
        .bit_tick_in    (tick),
        .octet_in       (oct),
        .octet_take_out (take),
        .bit_out        (dl_bit_out)
    );

    // BIT_ORIENTED_SIGNALLING message is one octet here; longer messages are out of scope
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_r       <= 1'b0;
            busy_buf_r   <= 1'b0;
            mode_mos_r   <= 1'b0;
            idx_r        <= '0;
            reps_r       <= '0;
            abort_pend_r <= 1'b0;
            eot_pulse    <= 1'b0;
        end else begin
            eot_pulse <= 1'b0;
            if (start) begin
                abort_pend_r <= mos_active && !ctrl_r.signalling_type_select
                                && !ctrl_r.abort_disable;
                busy_r     <= 1'b1;
                busy_buf_r <= pwdata_in[`DLTX_COUNT_SEL_BIT];
                mode_mos_r <= ctrl_r.signalling_type_select;
                idx_r      <= '0;
                reps_r     <= '0;
            end else if (take) begin
                if (abort_pend_r) begin
                    abort_pend_r <= 1'b0;
                end else if (busy_r && !mode_mos_r) begin
                    if (count_r != '0 && reps_r + 7'h1 == count_r) begin
                        busy_r    <= 1'b0;
                        eot_pulse <= 1'b1;
                    end else begin
                        reps_r <= (count_r == '0) ? reps_r : reps_r + 7'h1;
                    end
                end else if (mos_active) begin
                    if ((src == DLTX_SRC_DATA && idx_r + 7'h1 == count_r && !fcs_on)
                        || src == DLTX_SRC_FCS_HI) begin
                        busy_r    <= 1'b0;
                        eot_pulse <= 1'b1;
                    end else begin
                        idx_r <= idx_r + 7'h1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence eot_seen;
        eot_pulse;
    endsequence

    idle_means_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!busy_r && !abort_pend_r) |-> oct.octet == `DLTX_FLAG_OCTET && !oct.stuff_en)
        else $error("idle octet is not a flag");
    force_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ctrl_r.force_idle && mode_mos_r && !abort_pend_r) |-> src == DLTX_SRC_FLAG)
        else $error("force idle did not override frame");
    bos_ignore_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (busy_r && !mode_mos_r && !abort_pend_r) |-> src == DLTX_SRC_DATA)
        else $error("bit-oriented message blocked");
    eot_sets_status_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        eot_seen |=> status_r)
        else $error("end of transfer not recorded");
    endless_bos_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (busy_r && !mode_mos_r && count_r == '0) |-> !eot_pulse)
        else $error("endless repeat terminated");
    free_buffer_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        busy_r |-> next_free != busy_buf_r)
        else $error("free buffer points at busy one");
    no_fcs_bos_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !mode_mos_r |-> src != DLTX_SRC_FCS_LO && src != DLTX_SRC_FCS_HI)
        else $error("check octet in bit-oriented mode");
    select_follows_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        start |=> busy_r && busy_buf_r == $past(pwdata_in[`DLTX_COUNT_SEL_BIT]))
        else $error("buffer select not taken");
    abort_first_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        abort_pend_r |-> oct.octet == `DLTX_ABORT_OCTET)
        else $error("abort octet not sent");

endmodule

/* File: include/dltx_defines.svh */
// Register offsets, field positions, reset values and protocol constants of the data-link transmitter
`ifndef DLTX_DEFINES_SVH
`define DLTX_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define DLTX_CTRL_ADDR      12'h000
`define DLTX_COUNT_ADDR     12'h004
`define DLTX_STATUS_ADDR    12'h008
`define DLTX_MASK_ADDR      12'h00c
`define DLTX_BUF0_BASE      12'h600
`define DLTX_BUF1_BASE      12'h700
`define DLTX_BUF_SEL_BIT    8
`define DLTX_BUF_IDX_HI     8
`define DLTX_BUF_IDX_LO     2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DLTX_CTRL_TYPE_BIT   0
`define DLTX_CTRL_FCS_BIT    1
`define DLTX_CTRL_IDLE_BIT   2
`define DLTX_CTRL_ABDIS_BIT  6
`define DLTX_COUNT_SEL_BIT   7
`define DLTX_STAT_EOT_BIT    0

// ----------------------------------------------------------------
// Reset values and protocol constants
// ----------------------------------------------------------------
`define DLTX_CTRL_RESET      8'h00
`define DLTX_COUNT_RESET     7'h00
`define DLTX_FLAG_OCTET      8'h7e
`define DLTX_ABORT_OCTET     8'hfe
`define DLTX_FCS_INIT        16'hffff
`define DLTX_FCS_POLY_REV    16'h8408
`define DLTX_ONES_LIMIT      3'h5
`define DLTX_BIT_LAST        3'h7

`endif

/* File: include/dltx_pkg.sv */
// Types shared by the data-link transmitter modules
package dltx_pkg;

    typedef struct packed {
        logic       abort_disable;
        logic       force_idle;
        logic       check_octet_append;
        logic       signalling_type_select;
    } dltx_ctrl_s;

    typedef enum logic [2:0] {
        DLTX_SRC_FLAG,
        DLTX_SRC_ABORT,
        DLTX_SRC_DATA,
        DLTX_SRC_FCS_LO,
        DLTX_SRC_FCS_HI
    } dltx_src_e;

    typedef struct packed {
        logic [7:0] octet;
        logic       stuff_en;
        logic       first;
    } dltx_octet_s;

endpackage

/* File: verilog/dltx_fcs16.sv */
// Frame check sequence accumulator, one octet per update
`timescale 1ns/1ps
`include "dltx_defines.svh"

module dltx_fcs16 (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        init_in,
    input  wire logic        update_in,
    input  wire logic [7:0]  octet_in,
    output logic      [15:0] fcs_out
);

    logic [15:0] crc_r;
    logic [15:0] crc_nxt;

    always_comb begin
        crc_nxt = crc_r;
        for (int i = 0; i < 8; i++) begin
            if (crc_nxt[0] ^ octet_in[i]) begin
                crc_nxt = (crc_nxt >> 1) ^ `DLTX_FCS_POLY_REV;
            end else begin
                crc_nxt = crc_nxt >> 1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            crc_r <= `DLTX_FCS_INIT;
        end else if (init_in) begin
            crc_r <= `DLTX_FCS_INIT;
        end else if (update_in) begin
            crc_r <= crc_nxt;
        end
    end

    // Sent complemented, low octet first
    assign fcs_out = ~crc_r;

endmodule

/* File: verilog/dltx_serializer.sv */
// Octet to bit serialiser with zero-bit insertion
`timescale 1ns/1ps
`include "dltx_defines.svh"

module dltx_serializer
    import dltx_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        bit_tick_in,
    input  dltx_octet_s      octet_in,
    output logic             octet_take_out,
    output logic             bit_out
);

    logic [7:0] shift_r;
    logic [2:0] bit_idx_r;
    logic [2:0] ones_r;
    logic       stuff_r;
    logic       bit_r;
    logic       stuff_now;

    // Only stuffed ones count, so a frame ending in five ones still gets its zero before the next flag
    assign stuff_now      = (ones_r == `DLTX_ONES_LIMIT);
    assign octet_take_out = bit_tick_in && !stuff_now && (bit_idx_r == `DLTX_BIT_LAST);
    assign bit_out        = bit_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_r   <= `DLTX_FLAG_OCTET;
            bit_idx_r <= '0;
            ones_r    <= '0;
            stuff_r   <= 1'b0;
            bit_r     <= 1'b1;
        end else if (bit_tick_in) begin
            if (stuff_now) begin
                bit_r  <= 1'b0;
                ones_r <= '0;
            end else begin
                bit_r     <= shift_r[0];
                ones_r    <= (shift_r[0] && stuff_r) ? ones_r + 3'h1 : 3'h0;
                bit_idx_r <= bit_idx_r + 3'h1;
                if (bit_idx_r == `DLTX_BIT_LAST) begin
                    shift_r <= octet_in.octet;
                    stuff_r <= octet_in.stuff_en;
                end else begin
                    shift_r <= shift_r >> 1;
                end
            end
        end
    end

endmodule

/* File: bench/dltx_remote_rx.sv */
// Remote terminal model: recovers line bits, strips flags and inserted zeros, keeps the last frame
`timescale 1ns/1ps

module dltx_remote_rx #(
    parameter int BIT_DIV = 2
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic bit_in
);
    // ----------------------------------------------------------------
    // Bit recovery and deframing
    // ----------------------------------------------------------------
    logic        prev_r;
    logic        inframe_r;
    logic [7:0]  oct_r;
    logic [63:0] acc_r;
    logic [63:0] frame;
    int          phase;
    int          ones;
    int          nbits;
    int          cnt;
    int          frames;
    int          aborts;
    int          len;

    task automatic rx_bit(input logic b);
        if (!b && ones == 6) begin
            if (inframe_r && cnt > 0) begin
                frames++;
                len   = cnt;
                frame = acc_r;
            end
            inframe_r = 1'b1;
            cnt       = 0;
            nbits     = 0;
            acc_r     = '0;
        end else if (b && ones == 6) begin
            aborts++;
            inframe_r = 1'b0;
        end else if (b || ones != 5) begin
            oct_r = {b, oct_r[7:1]};
            nbits++;
            if (nbits == 8) begin
                if (cnt < 8) begin
                    acc_r[8*cnt +: 8] = oct_r;
                end
                cnt++;
                nbits = 0;
            end
        end
        ones = b ? ((ones < 6) ? ones + 1 : 6) : 0;
    endtask

    // No strobe comes with the line, so bit timing resyncs on every edge of it
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_r    = 1'b1;
            inframe_r = 1'b0;
            oct_r     = 8'h00;
            acc_r     = '0;
            frame     = '0;
            phase     = 0;
            ones      = 0;
            nbits     = 0;
            cnt       = 0;
            frames    = 0;
            aborts    = 0;
            len       = 0;
        end else if ((bit_in !== prev_r) || (phase == BIT_DIV)) begin
            phase  = 1;
            prev_r = bit_in;
            rx_bit(bit_in);
        end else begin
            phase++;
        end
    end
endmodule

/* File: bench/datalink_tx_msg_controller_tb.sv */
// Self-checking bench for the data-link transmit message controller
`timescale 1ns/1ps
`include "dltx_defines.svh"

module datalink_tx_msg_controller_tb;
    localparam int BIT_DIV = 2;
    logic        clk_in;
    logic        rst_n_in;
    logic        psel_in;
    logic        penable_in;
    logic        pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        irq_out;
    logic        dl_bit_out;
    logic [31:0] rdata;
    logic        err;
    int          miscompares;
    int          total_checks;

    dltx_controller #(.BUF_DEPTH(64), .BIT_DIV(BIT_DIV)) dut (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .psel_in     (psel_in),
        .penable_in  (penable_in),
        .pwrite_in   (pwrite_in),
        .paddr_in    (paddr_in),
        .pwdata_in   (pwdata_in),
        .prdata_out  (prdata_out),
        .pready_out  (pready_out),
        .pslverr_out (pslverr_out),
        .irq_out     (irq_out),
        .dl_bit_out  (dl_bit_out)
    );
    dltx_remote_rx #(.BIT_DIV(BIT_DIV)) far_end (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .bit_in   (dl_bit_out)
    );
    always #2.5 clk_in = ~clk_in;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered and left just after a rising edge; one idle edge keeps drives apart
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel_in    <= 1'b1;
        pwrite_in  <= w;
        paddr_in   <= a;
        pwdata_in  <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        chk(n, (n < 20) ? n : 0);
        rdata = prdata_out;
        err   = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask

    task automatic load(input logic sel, input logic [63:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            apb(1'b1, (sel ? `DLTX_BUF1_BASE : `DLTX_BUF0_BASE) + 12'(4 * i), {24'h0, d[8*i +: 8]});
        end
    endtask

    task automatic wait_eot(input int f0);
        int n;
        n = 0;
        do begin
            apb(1'b0, `DLTX_STATUS_ADDR, 32'h0);
            n++;
        end while (rdata[0] !== 1'b1 && n < 400);
        chk({31'h0, rdata[0]}, 32'h1);
        n = 0;
        while (far_end.frames == f0 && n < 400) begin
            @(posedge clk_in);
            n++;
        end
        chk(far_end.frames, f0 + 1);
    endtask

    function automatic logic [15:0] fcs16(input logic [63:0] b, input int n);
        logic [15:0] c;
        c = `DLTX_FCS_INIT;
        for (int i = 0; i < 8 * n; i++) begin
            c = (c[0] ^ b[i]) ? ((c >> 1) ^ `DLTX_FCS_POLY_REV) : (c >> 1);
        end
        return ~c;
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd_chk(`DLTX_CTRL_ADDR, 32'h0);
        rd_chk(`DLTX_COUNT_ADDR, 32'h0);
        rd_chk(`DLTX_STATUS_ADDR, 32'h0);
        apb(1'b1, 12'h010, 32'hff);
        chk({31'h0, err}, 32'h1);
        rd_chk(12'h010, 32'h0);
        chk({31'h0, err}, 32'h1);
        repeat (100) @(posedge clk_in);
        chk(far_end.frames + far_end.aborts, 0);
        $display("reset test done");
    endtask

    task automatic t_frame(input logic sel, input logic fcs_on, input logic [63:0] d, input int n);
        logic [63:0] exp;
        int          f0;
        exp = d;
        if (fcs_on) begin
            exp[8*n +: 16] = fcs16(d, n);
        end
        f0 = far_end.frames;
        apb(1'b1, `DLTX_STATUS_ADDR, 32'h1);
        load(sel, d, n);
        apb(1'b1, `DLTX_CTRL_ADDR, {30'h0, fcs_on, 1'b1});
        apb(1'b1, `DLTX_COUNT_ADDR, {24'h0, sel, n[6:0]});
        apb(1'b0, `DLTX_COUNT_ADDR, 32'h0);
        chk({31'h0, rdata[7]}, {31'h0, ~sel});
        wait_eot(f0);
        chk(far_end.len, n + (fcs_on ? 2 : 0));
        chk(far_end.frame[31:0], exp[31:0]);
        chk(far_end.frame[63:32], exp[63:32]);
        $display("frame test done");
    endtask

    task automatic t_irq();
        chk({31'h0, irq_out}, 32'h0);
        apb(1'b1, `DLTX_MASK_ADDR, 32'h1);
        @(posedge clk_in);
        chk({31'h0, irq_out}, 32'h1);
        rd_chk(`DLTX_MASK_ADDR, 32'h1);
        apb(1'b1, `DLTX_STATUS_ADDR, 32'h1);
        @(posedge clk_in);
        chk({31'h0, irq_out}, 32'h0);
        rd_chk(`DLTX_STATUS_ADDR, 32'h0);
        $display("interrupt test done");
    endtask

    task automatic t_bos();
        int f0;
        f0 = far_end.frames;
        apb(1'b1, `DLTX_STATUS_ADDR, 32'h1);
        load(1'b0, 64'h3c, 1);
        apb(1'b1, `DLTX_CTRL_ADDR, 32'h6);
        apb(1'b1, `DLTX_COUNT_ADDR, 32'h3);
        wait_eot(f0);
        chk(far_end.len, 3);
        chk(far_end.frame[31:0], 32'h3c3c3c);
        repeat (200) @(posedge clk_in);
        chk(far_end.frames, f0 + 1);
        $display("repeat test done");
    endtask

    task automatic t_idle();
        logic sel;
        int   f0;
        apb(1'b0, `DLTX_COUNT_ADDR, 32'h0);
        sel = rdata[7];
        f0  = far_end.frames;
        apb(1'b1, `DLTX_STATUS_ADDR, 32'h1);
        load(sel, 64'h0201, 2);
        apb(1'b1, `DLTX_CTRL_ADDR, 32'h5);
        apb(1'b1, `DLTX_COUNT_ADDR, {24'h0, sel, 7'h2});
        repeat (300) @(posedge clk_in);
        chk(far_end.frames, f0);
        rd_chk(`DLTX_STATUS_ADDR, 32'h0);
        apb(1'b1, `DLTX_CTRL_ADDR, 32'h1);
        wait_eot(f0);
        chk(far_end.frame[31:0], 32'h0201);
        $display("idle test done");
    endtask

    task automatic t_abort();
        int a0;
        int f0;
        apb(1'b1, `DLTX_STATUS_ADDR, 32'h1);
        load(1'b0, 64'h3c, 1);
        apb(1'b1, `DLTX_CTRL_ADDR, 32'h0);
        apb(1'b1, `DLTX_COUNT_ADDR, 32'h0);
        repeat (400) @(posedge clk_in);
        rd_chk(`DLTX_STATUS_ADDR, 32'h0);
        load(1'b1, 64'h1111111111111111, 8);
        for (int dis = 0; dis < 2; dis++) begin
            a0 = far_end.aborts;
            f0 = far_end.frames;
            apb(1'b1, `DLTX_STATUS_ADDR, 32'h1);
            apb(1'b1, `DLTX_CTRL_ADDR, {25'h0, dis[0], 6'h1});
            apb(1'b1, `DLTX_COUNT_ADDR, 32'h88);
            repeat (60) @(posedge clk_in);
            apb(1'b1, `DLTX_CTRL_ADDR, {25'h0, dis[0], 6'h0});
            apb(1'b1, `DLTX_COUNT_ADDR, 32'h1);
            wait_eot(f0);
            chk(far_end.aborts, a0 + 1 - dis);
        end
        $display("abort test done");
    endtask

    initial begin
        clk_in       = 1'b0;
        rst_n_in     = 1'b0;
        psel_in      = 1'b0;
        penable_in   = 1'b0;
        pwrite_in    = 1'b0;
        paddr_in     = 12'h000;
        pwdata_in    = 32'h0;
        miscompares  = 0;
        total_checks = 0;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        t_reset();
        t_frame(1'b0, 1'b1, 64'h7eff1f03, 4);
        t_irq();
        t_frame(1'b1, 1'b0, 64'h81fe, 2);
        t_bos();
        t_idle();
        t_abort();
        conclude();
    end

    // Tests need well under this; a hang still ends in the verdict
    initial begin
        repeat (60000) @(posedge clk_in);
        miscompares++;
        conclude();
    end
endmodule
